// [hdl/tap_ctrl.sv]
/*
 * Test access port controller with a 3-bit instruction register and three
 * selectable data paths: bypass cell, 10-bit debug channel and 3-bit
 * programming channel.
 * Assumes the host drives the link pins and that the debug and programming
 * engines present parallel words on the user side.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tap_consts.svh"

////////////////////////////////////////////////////////////////////////////////

module tap_ctrl
   import tap_pkg::*;
#(
   parameter int DBG_W  = `TAP_DBG_W,
   parameter int PROG_W = `TAP_PROG_W
)
(
   // System clock and reset.
   input  wire logic              clk_sys_i,
   input  wire logic              rst_n_i,
   // Link pins.
   input  wire logic              tck_i,
   input  wire logic              tms_i,
   input  wire logic              tdi_i,
   output logic                   tdo_o,
   output logic                   tdo_oe_o,
   // Debug channel user side.
   input  wire logic [DBG_W-1:0]  dbg_tx_i,
   output logic      [DBG_W-1:0]  dbg_rx_o,
   output logic                   dbg_upd_o,
   // Programming channel user side.
   input  wire logic [PROG_W-1:0] prog_tx_i,
   output logic      [PROG_W-1:0] prog_rx_o,
   output logic                   prog_upd_o,
   // Status.
   output logic      [2:0]        parallel_instruction_register_o,
   output var tap_state_t         state_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.

   logic             tck_rise;     // One-cycle strobe, rising test clock.
   logic             tck_fall;     // One-cycle strobe, falling test clock.
   logic             tms;          // Synchronised mode select.
   logic             tdi;          // Synchronised data input.
   tap_state_t       state;        // Controller state.
   tap_state_t       next_state;   // Controller state after the next rise.
   logic [2:0]       ir_shift;     // Instruction shift register.
   logic [2:0]       ir_par;       // Parallel instruction register.
   dr_path_t         path;         // Selected data register path.
   logic             byp_cell;     // Single bypass cell.
   logic [DBG_W-1:0] dbg_shift;    // Debug data shift register.
   logic [PROG_W-1:0] prog_shift;  // Programming data shift register.
   logic [2:0]       high_run;     // Helper: consecutive TMS-high rises.

   // Decode an instruction into a path; no-ops and reserved keep the old one.
   function automatic dr_path_t decode_path(input logic [2:0] op, input dr_path_t cur);
      dr_path_t sel;
      sel = cur;
      case (op)
         `TAP_OP_DEBUG: sel = PATH_DEBUG;
         `TAP_OP_PROG:  sel = PATH_PROG;
         `TAP_OP_BYP0, `TAP_OP_BYP1, `TAP_OP_BYP2: sel = PATH_BYPASS;
         default:       sel = cur;
      endcase
      return sel;
   endfunction : decode_path

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation.

   tap_link_sync u_sync
   (
      .clk_sys_i  (clk_sys_i),
      .rst_n_i    (rst_n_i),
      .tck_i      (tck_i),
      .tms_i      (tms_i),
      .tdi_i      (tdi_i),
      .tck_rise_o (tck_rise),
      .tck_fall_o (tck_fall),
      .tms_o      (tms),
      .tdi_o      (tdi)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Controller state machine.

   // Next state from the standard graph, steered by sampled mode select.
   always_comb
   begin
      case (state)
         ST_RESET:    next_state = tms ? ST_RESET    : ST_IDLE;
         ST_IDLE:     next_state = tms ? ST_SEL_DR   : ST_IDLE;
         ST_SEL_DR:   next_state = tms ? ST_SEL_IR   : ST_CAP_DR;
         ST_CAP_DR:   next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_SHIFT_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_EXIT1_DR: next_state = tms ? ST_UPD_DR   : ST_PAUSE_DR;
         ST_PAUSE_DR: next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
         ST_EXIT2_DR: next_state = tms ? ST_UPD_DR   : ST_SHIFT_DR;
         ST_UPD_DR:   next_state = tms ? ST_SEL_DR   : ST_IDLE;
         ST_SEL_IR:   next_state = tms ? ST_RESET    : ST_CAP_IR;
         ST_CAP_IR:   next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_SHIFT_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_EXIT1_IR: next_state = tms ? ST_UPD_IR   : ST_PAUSE_IR;
         ST_PAUSE_IR: next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
         ST_EXIT2_IR: next_state = tms ? ST_UPD_IR   : ST_SHIFT_IR;
         ST_UPD_IR:   next_state = tms ? ST_SEL_DR   : ST_IDLE;
         default:     next_state = ST_RESET;
      endcase
   end

   // State moves only on a test clock rise, so a stopped clock holds it.
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         state <= ST_RESET;
      else if (tck_rise)
         state <= next_state;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Instruction register.

   // Shifter captures on rises; the parallel copy updates on the fall.
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ir_shift <= `TAP_IR_CAPTURE;
         ir_par   <= `TAP_IR_RESET;
         path     <= PATH_BYPASS;
      end
      else
      begin
         if (tck_rise && state == ST_CAP_IR)
            ir_shift <= `TAP_IR_CAPTURE;
         else if (tck_rise && state == ST_SHIFT_IR)
            ir_shift <= {tdi, ir_shift[2:1]};
         if (state == ST_RESET)
         begin
            ir_par <= `TAP_IR_RESET;
            path   <= PATH_BYPASS;
         end
         else if (tck_fall && state == ST_UPD_IR)
         begin
            ir_par <= ir_shift;
            path   <= decode_path(ir_shift, path);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data registers.

   // Only the selected register shifts; the instruction register is untouched.
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         byp_cell   <= 1'h0;
         dbg_shift  <= '0;
         prog_shift <= '0;
         dbg_rx_o   <= '0;
         prog_rx_o  <= '0;
      end
      else
      begin
         if (tck_rise && state == ST_CAP_DR)
            byp_cell <= 1'h0;
         else if (tck_rise && state == ST_SHIFT_DR)
         begin
            case (path)
               PATH_DEBUG: dbg_shift  <= {tdi, dbg_shift[DBG_W-1:1]};
               PATH_PROG:  prog_shift <= {tdi, prog_shift[PROG_W-1:1]};
               default:    byp_cell   <= tdi;
            endcase
         end
         else if (tck_fall && state == ST_UPD_DR)
         begin
            case (path)
               PATH_DEBUG:
               begin
                  dbg_rx_o  <= dbg_shift;
                  dbg_shift <= dbg_tx_i;
               end
               PATH_PROG:
               begin
                  prog_rx_o  <= prog_shift;
                  prog_shift <= prog_tx_i;
               end
               default: byp_cell <= byp_cell;
            endcase
         end
      end
   end

   // Update strobes to the channel engines, one system clock long.
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         dbg_upd_o  <= 1'h0;
         prog_upd_o <= 1'h0;
      end
      else
      begin
         dbg_upd_o  <= tck_fall && state == ST_UPD_DR && path == PATH_DEBUG;
         prog_upd_o <= tck_fall && state == ST_UPD_DR && path == PATH_PROG;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Test data output.

   // Driven on falls in shift states only; otherwise idle high, not enabled.
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tdo_o    <= 1'h1;
         tdo_oe_o <= 1'h0;
      end
      else if (tck_fall)
      begin
         tdo_oe_o <= (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR);
         if (state == ST_SHIFT_IR)
            tdo_o <= ir_shift[0];
         else if (state == ST_SHIFT_DR)
            case (path)
               PATH_DEBUG: tdo_o <= dbg_shift[0];
               PATH_PROG:  tdo_o <= prog_shift[0];
               default:    tdo_o <= byp_cell;
            endcase
         else
            tdo_o <= 1'h1;
      end
   end

   assign parallel_instruction_register_o = ir_par;
   assign state_o                         = state;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   // Counts consecutive rises with mode select high, saturating.
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         high_run <= 3'h0;
      else if (tck_rise)
         high_run <= tms ? ((high_run == 3'h7) ? high_run : high_run + 3'h1) : 3'h0;
   end

   property p_five_high;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (high_run >= 3'(`TAP_RESET_EDGES)) |-> (state == ST_RESET);
   endproperty
   a_five_high: assert property (p_five_high) else $error("five TMS-high edges missed reset");

   property p_capture_ir;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (tck_rise && state == ST_CAP_IR) |=> (ir_shift == `TAP_IR_CAPTURE);
   endproperty
   a_capture_ir: assert property (p_capture_ir) else $error("capture-IR pattern wrong");

   property p_shift_ir;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (tck_rise && state == ST_SHIFT_IR) |=> (ir_shift == {$past(tdi), $past(ir_shift[2:1])});
   endproperty
   a_shift_ir: assert property (p_shift_ir) else $error("IR shift wrong");

   property p_update_ir;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (tck_fall && state == ST_UPD_IR) |=> (ir_par == $past(ir_shift));
   endproperty
   a_update_ir: assert property (p_update_ir) else $error("IR update missed");

   property p_reset_bypass;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state == ST_RESET) |=> (ir_par == `TAP_IR_RESET && path == PATH_BYPASS);
   endproperty
   a_reset_bypass: assert property (p_reset_bypass) else $error("reset not bypass");

   property p_ir_hold;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state != ST_RESET && !(tck_fall && state == ST_UPD_IR)) |=> $stable(ir_par);
   endproperty
   a_ir_hold: assert property (p_ir_hold) else $error("IR changed outside update");

   property p_stopped_clock;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !tck_rise |=> $stable(state);
   endproperty
   a_stopped_clock: assert property (p_stopped_clock) else $error("state moved w/o rise");

   property p_tdo_idle;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (tck_fall && state != ST_SHIFT_IR && state != ST_SHIFT_DR) |=> !tdo_oe_o;
   endproperty
   a_tdo_idle: assert property (p_tdo_idle) else $error("TDO enabled outside shift");

   property p_debug_sel;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (tck_fall && state == ST_UPD_IR && ir_shift == `TAP_OP_DEBUG) |=> (path == PATH_DEBUG);
   endproperty
   a_debug_sel: assert property (p_debug_sel) else $error("debug path not selected");

endmodule : tap_ctrl

`default_nettype wire

// [hdl/tap_link_sync.sv]
/*
 * Two-stage synchroniser with edge detection for the test clock and
 * registered copies of the other link inputs.
 * Assumes all inputs are asynchronous to clk_sys_i, and the link clock is
 * at most one eighth of the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tap_link_sync
(
   // Clock and reset.
   input  wire logic clk_sys_i,
   input  wire logic rst_n_i,
   // Raw link pins.
   input  wire logic tck_i,
   input  wire logic tms_i,
   input  wire logic tdi_i,
   // Synchronised results.
   output logic      tck_rise_o,
   output logic      tck_fall_o,
   output logic      tms_o,
   output logic      tdi_o
);

   logic [1:0] meta;     // First stage: test clock and mode select.
   logic [1:0] stable;   // Second stage: test clock and mode select.
   logic       tdi_meta; // First stage of the data input.
   logic       tdi_hold; // Second stage of the data input.
   logic       tck_last; // Previous synchronised test clock, for edges.

   // Only the second stage feeds any logic, so metastability stays contained.
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta     <= 2'h0;
         stable   <= 2'h0;
         tdi_meta <= 1'h1;
         tdi_hold <= 1'h1;
         tck_last <= 1'h0;
      end
      else
      begin
         meta     <= {tms_i, tck_i};
         stable   <= meta;
         tdi_meta <= tdi_i;
         tdi_hold <= tdi_meta;
         tck_last <= stable[0];
      end
   end

   // Edge strobes last exactly one system clock.
   assign tck_rise_o = stable[0] & ~tck_last;
   assign tck_fall_o = ~stable[0] & tck_last;
   assign tms_o      = stable[1];
   assign tdi_o      = tdi_hold;

endmodule : tap_link_sync

`default_nettype wire

// [shared/tap_consts.svh]
/*
 * Timing and encoding constants for the test access port block.
 * Assumes it is included by bare name from shared/ on the include path.
 */
`ifndef TAP_CONSTS_SVH
`define TAP_CONSTS_SVH

// Instruction register width, capture pattern and reset value.
`define TAP_IR_W           3
`define TAP_IR_CAPTURE     3'h1
`define TAP_IR_RESET       3'h3

// Instruction codes.
`define TAP_OP_EXTEST      3'h0
`define TAP_OP_SAMPLE      3'h1
`define TAP_OP_DEBUG       3'h2
`define TAP_OP_BYP0        3'h3
`define TAP_OP_PROG        3'h4
`define TAP_OP_BYP1        3'h5
`define TAP_OP_RSVD        3'h6
`define TAP_OP_BYP2        3'h7

// Data register lengths.
`define TAP_DBG_W          10
`define TAP_PROG_W         3

// Mode select high edges that always reach test-logic-reset.
`define TAP_RESET_EDGES    5

`endif

// [shared/tap_pkg.sv]
/*
 * Types shared by the test access port design files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package tap_pkg;

   // Sixteen controller states, encoded 0 to 15 in declaration order.
   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE,
      ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
      ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
   } tap_state_t;

   // Selected serial data path.
   typedef enum logic [1:0] {
      PATH_BYPASS, PATH_DEBUG, PATH_PROG
   } dr_path_t;

endpackage : tap_pkg

`default_nettype wire

// [testbench/jtag_host_model.sv]
/*
 * Behavioural host controller that drives the test link pins by task calls.
 * Assumes each task is entered with the link clock low, off the system clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module jtag_host_model
(
   // Link pins towards the device.
   output logic      tck_o,
   output logic      tms_o,
   output logic      tdi_o,
   // Data returned by the device.
   input  wire logic tdo_i
);
   // The clock rests low between frames, which freezes the device's state.
   // Mode and data rest at their pull-up level so a released line never looks driven low.
   initial
   begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////

   // One 64 ns link period: set up while low, hold across the rise.
   // The returned bit is taken late in the high phase, where it has long settled.
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      tms_o = tms;
      tdi_o = tdi;
      #32 tck_o = 1'b1;
      #31 tdo = tdo_i;
      #1 tck_o = 1'b0;
   endtask : step

   // Sends n mode bits, bit 0 first, with the data line released.
   task automatic walk(input logic [7:0] seq, input int n);
      logic unused;
      for (int i = 0; i < n; i++)
      begin
         step(seq[i], 1'b1, unused);
      end
   endtask : walk

   // Whole scan from idle back to idle, lowest bit first both ways.
   task automatic scan(input logic is_ir, input int n, input logic [9:0] din,
                       output logic [9:0] dout);
      logic bit_out;
      dout = 10'h000;
      walk(is_ir ? 8'h03 : 8'h01, is_ir ? 4 : 3);
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i], bit_out);
         dout[i] = bit_out;
      end
      walk(8'h01, 2);
   endtask : scan

endmodule : jtag_host_model
`default_nettype wire

// [testbench/jtag_tap_ir_dr_scan_bench.sv]
/*
 * Self-checking bench for the test access port controller.
 * Assumes the host model drives the link and the design carries its own assertions.
 */
`timescale 1ns/1ps
`default_nettype none

module jtag_tap_ir_dr_scan_bench
   import tap_pkg::*;
;

   // One row: instruction code and the data path length it should leave selected.
   typedef struct packed
   {
      logic [2:0] code;
      logic [3:0] len;
   } row_t;

   // Codes 0, 1 and 6 keep the previous path, so row order matters.
   row_t rows [9] = '{'{3'h3, 4'd1}, '{3'h2, 4'd10}, '{3'h0, 4'd10}, '{3'h4, 4'd3},
                     '{3'h1, 4'd3}, '{3'h5, 4'd1}, '{3'h6, 4'd1}, '{3'h2, 4'd10},
                     '{3'h7, 4'd1}};

   logic       clk_sys_i;              // System clock.
   logic       rst_n_i;                // Reset, active low.
   logic       tck, tms, tdi, tdo;     // Link pins.
   logic       tdo_oe;                 // Output enable of the data pin.
   logic [9:0] dbg_tx, dbg_rx;         // Debug channel words.
   logic [2:0] prog_tx, prog_rx, pir;  // Programming words and instruction.
   logic       dbg_upd, prog_upd;      // Update pulses.
   tap_state_t state;                  // Controller state.
   logic [9:0] pat, sh, cap, exp;      // Scan pattern, result and expectations.
   int         errors = 0;             // Mismatches seen.
   int         checks_done = 0;        // Comparisons made.
   int         dbg_cnt = 0;            // Debug update pulses counted.
   int         prog_cnt = 0;           // Programming update pulses counted.
   int         d0, p0;                 // Pulse counts at row start.

   tap_ctrl tap_ctrl_i
   (
      .clk_sys_i                       (clk_sys_i),
      .rst_n_i                         (rst_n_i),
      .tck_i                           (tck),
      .tms_i                           (tms),
      .tdi_i                           (tdi),
      .tdo_o                           (tdo),
      .tdo_oe_o                        (tdo_oe),
      .dbg_tx_i                        (dbg_tx),
      .dbg_rx_o                        (dbg_rx),
      .dbg_upd_o                       (dbg_upd),
      .prog_tx_i                       (prog_tx),
      .prog_rx_o                       (prog_rx),
      .prog_upd_o                      (prog_upd),
      .parallel_instruction_register_o (pir),
      .state_o                         (state)
   );

   jtag_host_model jtag_host_model_i
   (
      .tck_o (tck),
      .tms_o (tms),
      .tdi_o (tdi),
      .tdo_i (tdo)
   );

   ////////////////////////////////////////////////////////////////////////////////

   // System clock of 8 ns.
   initial
   begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   // Pulses last one cycle, so they are counted on every edge.
   always @(posedge clk_sys_i)
   begin
      if (dbg_upd === 1'b1)
         dbg_cnt <= dbg_cnt + 1;
      if (prog_upd === 1'b1)
         prog_cnt <= prog_cnt + 1;
   end

   // Compares one value; case inequality keeps unknowns from passing.
   task automatic check(input string name, input logic [9:0] seen, input logic [9:0] want);
      checks_done++;
      if (seen !== want)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, want, seen);
      end
   endtask : check

   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop

   // Watchdog: the whole run needs well under 60 us.
   initial
   begin
      #150000;
      errors++;
      report_and_stop();
   end

   ////////////////////////////////////////////////////////////////////////////////

   initial
   begin
      rst_n_i <= 1'b0;
      dbg_tx  <= 10'h1b6;
      prog_tx <= 3'h5;
      repeat (16) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      #3;
      // Reset state, bypass code, released output; mode high keeps it there.
      check("state", {6'h00, state}, {6'h00, ST_RESET});
      check("instr", {7'h00, pir}, 10'h003);
      check("tdo_oe", {9'h000, tdo_oe}, 10'h000);
      jtag_host_model_i.walk(8'hff, 8);
      #200;
      check("state", {6'h00, state}, {6'h00, ST_RESET});
      jtag_host_model_i.walk(8'h00, 1);
      $display("reset test done");
      // Each row loads a code, then runs two data scans; the second shows the path.
      for (int r = 0; r < 9; r++)
      begin
         d0 = dbg_cnt;
         p0 = prog_cnt;
         pat = 10'h2c9 ^ 10'(r * 37);
         jtag_host_model_i.scan(1'b1, 3, {7'h00, rows[r].code}, sh);
         #200;
         check("ir_capture", sh, 10'h001);
         check("instr", {7'h00, pir}, {7'h00, rows[r].code});
         jtag_host_model_i.scan(1'b0, 10, ~pat, sh);
         jtag_host_model_i.scan(1'b0, 10, pat, sh);
         #200;
         case (rows[r].len)
            4'd10:   cap = dbg_tx;
            4'd3:    cap = {7'h00, prog_tx};
            default: cap = 10'h000;
         endcase
         exp = (pat << rows[r].len) | cap;
         check("dr_out", sh, exp);
         check("instr_kept", {7'h00, pir}, {7'h00, rows[r].code});
         check("dbg_upd", 10'(dbg_cnt - d0), (rows[r].len == 4'd10) ? 10'd2 : 10'd0);
         check("prog_upd", 10'(prog_cnt - p0), (rows[r].len == 4'd3) ? 10'd2 : 10'd0);
         if (rows[r].len == 4'd10)
            check("dbg_rx", dbg_rx, pat);
         if (rows[r].len == 4'd3)
            check("prog_rx", {7'h00, prog_rx}, {7'h00, pat[9:7]});
         $display("row %0d done", r);
      end
      // A stopped link clock must freeze the controller in idle.
      #400;
      check("state", {6'h00, state}, {6'h00, ST_IDLE});
      check("tdo_oe", {9'h000, tdo_oe}, 10'h000);
      $display("hold test done");
      // Abort in mid-shift with five mode-high edges.
      jtag_host_model_i.scan(1'b1, 3, 10'h002, sh);
      jtag_host_model_i.walk(8'h01, 3);
      #200;
      check("state", {6'h00, state}, {6'h00, ST_SHIFT_DR});
      check("tdo_oe", {9'h000, tdo_oe}, 10'h001);
      jtag_host_model_i.walk(8'h1f, 5);
      #200;
      check("state", {6'h00, state}, {6'h00, ST_RESET});
      check("instr", {7'h00, pir}, 10'h003);
      jtag_host_model_i.walk(8'h00, 1);
      jtag_host_model_i.scan(1'b0, 10, 10'h3a5, sh);
      #200;
      check("dr_out", sh, 10'h34a);
      $display("abort test done");
      // A private instruction is kept until a reset in mid-run drops it to bypass.
      jtag_host_model_i.scan(1'b1, 3, 10'h004, sh);
      #200;
      check("instr", {7'h00, pir}, 10'h004);
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      #3;
      check("state", {6'h00, state}, {6'h00, ST_RESET});
      check("instr", {7'h00, pir}, 10'h003);
      check("tdo_oe", {9'h000, tdo_oe}, 10'h000);
      check("tdo", {9'h000, tdo}, 10'h001);
      $display("mid reset test done");
      report_and_stop();
   end

endmodule : jtag_tap_ir_dr_scan_bench
`default_nettype wire
